// File: dlg_pkg.sv
// shared constants and types for the debug/led pin sharing gate
package dlg_pkg;
   // link clock edge count that completes an attach and enters the halted session
   localparam logic [3:0] DLG_ATTACH_EDGES = 4'h8;
   // idle time of the link clock line in us, counted in 10 MHz clk cycles, before a detach is taken
   localparam int DLG_IDLE_US = 200;
   localparam int DLG_CLK_MHZ = 10;
   localparam logic [11:0] DLG_IDLE_CYC = 12'(DLG_IDLE_US * DLG_CLK_MHZ);
   localparam logic DLG_SESSION_RST = 1'b0;
   localparam logic DLG_HALT_RST = 1'b0;

   typedef enum logic [1:0] {DLG_FREE, DLG_ATTACH, DLG_HALTED} dlg_state_t;

   // pin drive bundle: level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } dlg_drive_t;
endpackage

// File: dlg_gate.sv
// shared pin gate for the led current driver and the debug link clock
`timescale 1ns/1ps
// Notes on behaviour
// - led driver and link clock share one pin
// - connected session keeps led driver off
// - attach only while led driver inactive
// - detach releases halt and led block together (here led_drive_on can return only one clk after halt_stall clears)
// - pin toggling in session is link only
// - shutdown wakeup resets registers, full boot
// - power-on reset turns led driver off
// - halt stalls peripherals and user software
// - link: host clock, bidirectional data
module dlg_gate
   import dlg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic wake_rst,
   // application side
   input wire logic app_led_on,
   output logic led_drive_on,
   // debug session control from the link engine
   input wire logic dbg_detach_req,
   input wire logic dbg_dev_reset,
   output logic halt_stall,
   output logic session_active,
   output logic boot_start,
   // shared pin five: link clock in, led sink out
   input wire logic pin5_in,
   output logic pin5_out,
   output logic pin5_oe,
   // data pin four
   input wire logic pin4_in,
   output logic pin4_out,
   output logic pin4_oe,
   input wire logic link_data_out,
   input wire logic link_data_oe,
   output logic link_data_in,
   output logic link_clk_rise
);
   //------------------------------------------------------------
   // synchronisers
   //------------------------------------------------------------
   logic c_s1_r, c_s2_r, c_s3_r, d_s1_r, d_s2_r;
   always_ff @(posedge clk)
   begin
      c_s1_r <= pin5_in;
      c_s2_r <= c_s1_r;
      c_s3_r <= c_s2_r;
      d_s1_r <= pin4_in;
      d_s2_r <= d_s1_r;
   end
   wire logic rise_w = c_s2_r & ~c_s3_r;
   wire logic any_reset_w = rst | wake_rst | dbg_dev_reset;

   //------------------------------------------------------------
   // session state
   //------------------------------------------------------------
   dlg_state_t st_r, st_nxt;
   logic [3:0] edges_r, edges_nxt;
   logic [11:0] idle_r, idle_nxt;
   logic led_r;
   // attach is only allowed while the led driver is not sinking
   wire logic led_idle_w = ~led_r;
   wire logic idle_done_w = (idle_r == DLG_IDLE_CYC);
   wire logic detach_w = (st_r == DLG_HALTED) & (dbg_detach_req | idle_done_w);

   always_comb
   begin
      st_nxt = st_r;
      edges_nxt = edges_r;
      idle_nxt = rise_w ? 12'h000 : (idle_done_w ? idle_r : idle_r + 12'h001);
      unique case (st_r)
         DLG_FREE:
         begin
            edges_nxt = 4'h0;
            if (rise_w && led_idle_w)
            begin
               st_nxt = DLG_ATTACH;
               edges_nxt = 4'h1;
            end
         end
         DLG_ATTACH:
         begin
            if (!led_idle_w || idle_done_w)
               st_nxt = DLG_FREE;
            else if (rise_w)
               edges_nxt = edges_r + 4'h1;
            if (led_idle_w && edges_r == DLG_ATTACH_EDGES)
               st_nxt = DLG_HALTED;
         end
         DLG_HALTED:
            if (detach_w)
               st_nxt = DLG_FREE;
         // the unused fourth code falls back to the free state
         default:
            st_nxt = DLG_FREE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (any_reset_w)
      begin
         st_r <= DLG_FREE;
         edges_r <= 4'h0;
         idle_r <= 12'h000;
      end
      else
      begin
         st_r <= st_nxt;
         edges_r <= edges_nxt;
         idle_r <= idle_nxt;
      end
   end

   //------------------------------------------------------------
   // led gating and halt
   //------------------------------------------------------------
   wire logic in_session_w = (st_r == DLG_HALTED);
   // led latch is cleared by any reset so a stuck-on led can be recovered
   always_ff @(posedge clk)
   begin
      if (any_reset_w)
         led_r <= 1'b0;
      else
         led_r <= app_led_on & ~in_session_w & (st_nxt != DLG_HALTED);
   end
   logic boot_r;
   always_ff @(posedge clk)
   begin
      if (rst | wake_rst | dbg_dev_reset)
         boot_r <= 1'b1;
      else
         boot_r <= 1'b0;
   end
   assign boot_start = boot_r & ~any_reset_w;
   assign session_active = in_session_w;
   assign halt_stall = in_session_w;
   assign led_drive_on = led_r;

   //------------------------------------------------------------
   // pins
   //------------------------------------------------------------
   dlg_drive_t p5_w;
   // led is a current sink: pin driven low while lit, else released
   assign p5_w.out = 1'b0;
   assign p5_w.oe = led_r & ~in_session_w;
   assign pin5_out = p5_w.out;
   assign pin5_oe = p5_w.oe;
   assign pin4_out = link_data_out;
   assign pin4_oe = link_data_oe & in_session_w;
   assign link_data_in = d_s2_r;
   assign link_clk_rise = rise_w & in_session_w;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   sequence s_detach;
      in_session_w && dbg_detach_req;
   endsequence
   sequence s_idle_end;
      in_session_w && idle_done_w;
   endsequence
   sequence s_attach_led;
      (st_r == DLG_ATTACH) && led_r;
   endsequence
   no_led_session_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      in_session_w |-> !pin5_oe) else $error("led drives in session");
   led_block_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      in_session_w |=> !led_drive_on) else $error("led not blocked");
   attach_gate_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      $rose(in_session_w) |-> !$past(led_r)) else $error("attach with led");
   attach_count_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      $rose(in_session_w) |-> $past(edges_r) == DLG_ATTACH_EDGES)
      else $error("attach without full edge count");
   attach_abort_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      s_attach_led |=> st_r == DLG_FREE) else $error("attach not aborted");
   detach_both_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      s_detach |=> !halt_stall && !session_active) else $error("bad detach");
   led_resume_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      s_detach ##1 app_led_on |=> led_drive_on) else $error("led not resumed");
   idle_detach_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      s_idle_end |=> !session_active) else $error("idle detach missed");
   pin_quiet_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      in_session_w |-> pin5_oe == 1'b0 && pin5_out == 1'b0)
      else $error("pin5 toggled");
   boot_pulse_a:
      assert property (@(posedge clk)
      $fell(any_reset_w) |-> boot_start ##1 !boot_start) else $error("no boot");
   boot_cause_a:
      assert property (@(posedge clk)
      boot_start |-> $past(any_reset_w)) else $error("boot without reset");
   reset_clear_a:
      assert property (@(posedge clk)
      any_reset_w |=> !session_active && !pin4_oe)
      else $error("reset kept session");
   por_led_a:
      assert property (@(posedge clk)
      rst |=> !led_drive_on) else $error("led on after reset");
   halt_match_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      halt_stall == session_active) else $error("halt mismatch");
   data_own_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      !in_session_w |-> !pin4_oe) else $error("data driven idle");
   rise_own_a:
      assert property (@(posedge clk) disable iff (any_reset_w)
      link_clk_rise |-> session_active)
      else $error("link edge outside session");
endmodule

// File: dlg_adapter.sv
// debug adapter model: drives the link clock and data line
`timescale 1ns/1ps
module dlg_adapter
(
   // link lines
   output logic lclk,
   output logic dat,
   output logic dat_oe
);
   initial
   begin
      lclk = 1'b0;
      dat = 1'b0;
      dat_oe = 1'b0;
   end
   // clock stands low between bursts, 800 ns period
   task automatic burst(input int n);
      repeat (n)
      begin
         dat_oe = 1'b1;
         dat = 1'($urandom);
         #400 lclk = 1'b1;
         #400 lclk = 1'b0;
      end
      dat_oe = 1'b0;
   endtask
endmodule

// File: dlg_gate_tb.sv
// self-checking bench for the shared pin gate
`timescale 1ns/1ps
module dlg_gate_tb;
   import dlg_pkg::*;
   logic clk, rst, wake_rst, app_led_on, dbg_detach_req, dbg_dev_reset;
   logic led_drive_on, halt_stall, session_active, boot_start, lclk;
   logic pin5_out, pin5_oe, pin4_out, pin4_oe, link_data_in;
   logic link_clk_rise, link_data_out, link_data_oe, dat, dat_oe;
   // a released data line shows the inverse, not a stale level
   wire pin5_in = pin5_oe ? pin5_out : lclk;
   wire pin4_in = pin4_oe ? pin4_out : (dat_oe ? dat : ~dat);
   int error_cnt = 0;
   int comparisons = 0;
   int sess_m = 0;
   int rise_cnt = 0;
   int rise_base = 0;
   // counted on the falling edge, where the one-cycle pulse has settled
   always @(negedge clk)
   begin
      if (link_clk_rise === 1'b1)
         rise_cnt++;
   end
   dlg_gate uut (.clk(clk), .rst(rst), .wake_rst(wake_rst),
      .app_led_on(app_led_on), .led_drive_on(led_drive_on),
      .dbg_detach_req(dbg_detach_req), .dbg_dev_reset(dbg_dev_reset),
      .halt_stall(halt_stall), .session_active(session_active),
      .boot_start(boot_start), .pin5_in(pin5_in), .pin5_out(pin5_out),
      .pin5_oe(pin5_oe), .pin4_in(pin4_in), .pin4_out(pin4_out),
      .pin4_oe(pin4_oe), .link_data_out(link_data_out),
      .link_data_oe(link_data_oe), .link_data_in(link_data_in),
      .link_clk_rise(link_clk_rise));
   dlg_adapter adp (.lclk(lclk), .dat(dat), .dat_oe(dat_oe));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %b expected %b", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task model_chk;
      chk(session_active, sess_m[0]);
      chk(halt_stall, sess_m[0]);
      chk(led_drive_on, app_led_on & ~sess_m[0]);
      chk(pin5_oe, app_led_on & ~sess_m[0]);
      chk(pin5_out, 1'b0);
      chk(pin4_oe, link_data_oe & sess_m[0]);
   endtask
   task attach;
      adp.burst(8);
      for (int i = 0; i < 40 && session_active !== 1'b1; i++) step(1);
      // a session that never comes is a mismatch and ends the run
      if (session_active !== 1'b1)
      begin
         chk(session_active, 1'b1);
         stop_test;
      end
      sess_m = 1;
      step(2);
      model_chk;
   endtask
   task stop_test;
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      {rst, wake_rst, app_led_on, dbg_detach_req} = 4'h8;
      {dbg_dev_reset, link_data_out, link_data_oe} = 3'h0;
      void'($urandom(32'h73d5a47c));
      step(3);
      rst = 1'b0;
      #1;
      chk(boot_start, 1'b1);
      step(3);
      model_chk;
      app_led_on = 1'b1;
      step(3);
      adp.burst(8);
      step(4);
      model_chk;
      app_led_on = 1'b0;
      step(3);
      attach;
      repeat (8)
      begin
         {app_led_on, link_data_out, link_data_oe} = 3'($urandom);
         step(2);
         model_chk;
         chk(pin4_out, link_data_out);
         chk(link_data_in, link_data_oe ? link_data_out : ~dat);
      end
      link_data_oe = 1'b0;
      app_led_on = 1'b0;
      rise_base = rise_cnt;
      adp.burst(4);
      step(4);
      chk(rise_cnt == rise_base + 4, 1'b1);
      chk(link_data_in, ~dat);
      model_chk;
      app_led_on = 1'b1;
      dbg_detach_req = 1'b1;
      step(1);
      dbg_detach_req = 1'b0;
      sess_m = 0;
      step(1);
      chk(halt_stall, 1'b0);
      chk(session_active, 1'b0);
      step(1);
      chk(led_drive_on, 1'b1);
      // shutdown wakeup reset: registers cleared, led driver off, then boot
      app_led_on = 1'b1;
      step(1);
      chk(led_drive_on, 1'b1);
      wake_rst = 1'b1;
      step(1);
      chk(led_drive_on, 1'b0);
      chk(boot_start, 1'b0);
      wake_rst = 1'b0;
      // firmware rewrites its led request in full after a restart
      app_led_on = 1'b0;
      #1;
      chk(boot_start, 1'b1);
      step(3);
      attach;
      step(2010);
      sess_m = 0;
      model_chk;
      app_led_on = 1'b1;
      step(3);
      chk(led_drive_on, 1'b1);
      dbg_dev_reset = 1'b1;
      step(1);
      chk(led_drive_on, 1'b0);
      dbg_dev_reset = 1'b0;
      app_led_on = 1'b0;
      step(3);
      attach;
      dbg_dev_reset = 1'b1;
      step(1);
      sess_m = 0;
      model_chk;
      dbg_dev_reset = 1'b0;
      step(2);
      model_chk;
      stop_test;
   end
endmodule
